// *** include/cpu_pkg.sv ***
// package for the processor core: memory map, vectors, opcodes, states
// assumes a single clock domain and a combinational external memory
`default_nettype none
package cpu_pkg;
	localparam logic [15:0] PORT_DIR_ADDR = 16'h0000;
	localparam logic [15:0] PORT_OUT_ADDR = 16'h0001;
	localparam logic [6:0] INT_PAGES = 7'h00;
	localparam logic [7:0] STACK_HI = 8'h01;
	localparam logic [7:0] ZERO_PAGE = 8'h00;
	localparam logic [15:0] RST_VEC = 16'hfffc;
	localparam logic [15:0] IRQ_VEC = 16'hfffe;
	localparam logic [7:0] SP_RESET = 8'hff;
	localparam logic [7:0] PORT_RESET = 8'h00;
	localparam logic [2:0] INIT_CYCLES = 3'h6;
	localparam logic [2:0] INIT_LAST = INIT_CYCLES - 3'h1;
	// opcodes outside the regular group
	localparam logic [7:0] OP_JMP_ABS = 8'h4c;
	localparam logic [7:0] OP_JMP_IND = 8'h6c;
	localparam logic [7:0] OP_BNE = 8'hd0;
	localparam logic [7:0] OP_BEQ = 8'hf0;
	localparam logic [7:0] OP_LDX_I = 8'ha2;
	localparam logic [7:0] OP_LDY_I = 8'ha0;
	localparam logic [7:0] OP_CLI = 8'h58;
	localparam logic [7:0] OP_SEI = 8'h78;
	localparam logic [7:0] OP_ASL_A = 8'h0a;
	localparam logic [7:0] OP_LSR_A = 8'h4a;
	// regular group: opcode bits 1:0, function in bits 7:5
	localparam logic [1:0] GRP_ALU = 2'h1;
	localparam logic [2:0] FN_ORA = 3'h0;
	localparam logic [2:0] FN_AND = 3'h1;
	localparam logic [2:0] FN_EOR = 3'h2;
	localparam logic [2:0] FN_STA = 3'h4;
	localparam logic [2:0] FN_LDA = 3'h5;
	// addressing modes
	localparam logic [3:0] M_IMP = 4'h0;
	localparam logic [3:0] M_IMM = 4'h1;
	localparam logic [3:0] M_ZP = 4'h2;
	localparam logic [3:0] M_ZPX = 4'h3;
	localparam logic [3:0] M_ABS = 4'h4;
	localparam logic [3:0] M_ABSX = 4'h5;
	localparam logic [3:0] M_ABSY = 4'h6;
	localparam logic [3:0] M_INDX = 4'h7;
	localparam logic [3:0] M_INDY = 4'h8;
	localparam logic [3:0] M_REL = 4'h9;
	localparam logic [3:0] M_JABS = 4'ha;
	localparam logic [3:0] M_JIND = 4'hb;
	typedef enum logic [12:0] {
		ST_RST_HOLD = 13'h0001, ST_RST_INIT = 13'h0002,
		ST_VEC_LO = 13'h0004, ST_VEC_HI = 13'h0008,
		ST_FETCH = 13'h0010, ST_OP1 = 13'h0020, ST_OP2 = 13'h0040,
		ST_PTR_LO = 13'h0080, ST_PTR_HI = 13'h0100, ST_EXEC = 13'h0200,
		ST_PUSH_H = 13'h0400, ST_PUSH_L = 13'h0800, ST_PUSH_P = 13'h1000
	} cpu_state_e;

	function automatic logic [3:0] cpu_mode_of(input logic [7:0] op);
		if (op == OP_JMP_ABS) return M_JABS;
		else if (op == OP_JMP_IND) return M_JIND;
		else if (op == OP_BNE || op == OP_BEQ) return M_REL;
		else if (op == OP_LDX_I || op == OP_LDY_I) return M_IMM;
		else if (op[1:0] == GRP_ALU) begin
			case (op[4:2])
				3'h0: return M_INDX;
				3'h1: return M_ZP;
				3'h2: return M_IMM;
				3'h3: return M_ABS;
				3'h4: return M_INDY;
				3'h5: return M_ZPX;
				3'h6: return M_ABSY;
				default: return M_ABSX;
			endcase
		end
		else return M_IMP;
	endfunction

	function automatic logic [7:0] cpu_alu(input logic [2:0] fn,
		input logic [7:0] a, input logic [7:0] m);
		case (fn)
			FN_ORA: return a | m;
			FN_AND: return a & m;
			FN_EOR: return a ^ m;
			FN_LDA: return m;
			default: return a;
		endcase
	endfunction
endpackage
`default_nettype wire

// *** logic/cpu_core.sv ***
// 8-bit processor core with on-chip ram pages and an 8-bit port
// assumes external memory answers within the cycle its address is shown
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RQ1: no writes while restart input low
// RQ2: restart rising edge starts reset sequence immediately
// RQ3: six init cycles, set mask, vector fffc/fffd
// RQ4: system holds restart low two cycles minimum
// RQ5: read/write output valid during restart low
// RQ6: interrupt recognized only at instruction boundary
// RQ7: interrupt taken only when mask flag clear
// RQ8: interrupt stacks program counter and status
// RQ9: then set mask, vector fffe/ffff
// RQ10: address outputs float while bus enable low
// RQ11: port output at 0001, direction at 0000
// RQ12: read/write high except during write cycles
// RQ13: accumulator mode is one byte, no operand
// RQ14: immediate operand is second instruction byte
// RQ15: absolute address is second and third byte
// RQ16: zero page forces high address byte zero
// RQ17: zero page indexed wraps within page zero
// RQ18: absolute indexed adds index to base
// RQ19: branch adds signed offset to next address
// RQ20: indexed indirect pointer wraps in page zero
// RQ21: indirect indexed carries into high byte
// RQ22: absolute indirect loads pointer target into counter
// RQ23: each port pin direction set per bit
// RQ24: port read returns pin level for inputs
// RQ25: on-chip ram answers at pages zero and one
// RQ26: push high, low, status; stack decrements
module cpu_core (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// control inputs
	input wire logic restart_input_n,
	input wire logic irq_n,
	input wire logic bus_drive_enable,
	// system bus
	output logic [15:0] address_lines,
	output logic address_lines_oe,
	input wire logic [7:0] data_lines_i,
	output logic [7:0] data_lines_o,
	output logic data_lines_oe,
	output logic rw,
	// peripheral port
	input wire logic [7:0] port_pins_i,
	output logic [7:0] port_pins_o,
	output logic [7:0] port_pins_oe
);
	cpu_pkg::cpu_state_e st_q, st_d;
	logic [15:0] pc_q, pc_d, ptr_q, ptr_d, eff_q, eff_d, addr_q, addr_d;
	logic [7:0] a_q, a_d, x_q, x_d, y_q, y_d, sp_q, sp_d, ir_q, ir_d;
	logic [7:0] lo_q, lo_d, dout_q, dout_d, res, din;
	logic [7:0] dir_q, dir_d, out_q, out_d;
	logic [7:0] ram_q [0:255];
	logic [3:0] md_q, md_d;
	logic [2:0] cnt_q, cnt_d;
	logic [1:0] ld;
	logic n_q, n_d, z_q, z_d, c_q, c_d, i_q, i_d;
	logic rw_q, rw_d, aoe_q, doe_q, store, take, wr_ok;

	assign store = ir_q[1:0] == cpu_pkg::GRP_ALU && ir_q[7:5] == cpu_pkg::FN_STA;
	assign take = (ir_q == cpu_pkg::OP_BEQ) ? z_q : !z_q;
	assign wr_ok = !rw_q && restart_input_n; // RQ1

	// read data: port, on-chip ram, else external bus
	always_comb begin
		if (addr_q == cpu_pkg::PORT_DIR_ADDR) din = dir_q; // RQ11
		else if (addr_q == cpu_pkg::PORT_OUT_ADDR)
			din = (out_q & dir_q) | (port_pins_i & ~dir_q); // RQ24
		else if (addr_q[15:9] == cpu_pkg::INT_PAGES)
			din = ram_q[addr_q[7:0]]; // RQ25
		else din = data_lines_i;
	end

	// sequencer next state
	always_comb begin
		st_d = st_q;
		pc_d = pc_q;
		a_d = a_q;
		x_d = x_q;
		y_d = y_q;
		sp_d = sp_q;
		n_d = n_q;
		z_d = z_q;
		c_d = c_q;
		i_d = i_q;
		ir_d = ir_q;
		md_d = md_q;
		lo_d = lo_q;
		ptr_d = ptr_q;
		eff_d = eff_q;
		cnt_d = cnt_q;
		res = a_q;
		ld = 2'h0;
		case (st_q)
			cpu_pkg::ST_RST_HOLD: begin
				cnt_d = 3'h0;
				if (restart_input_n) st_d = cpu_pkg::ST_RST_INIT; // RQ2
			end
			cpu_pkg::ST_RST_INIT: begin
				cnt_d = cnt_q + 3'h1;
				if (cnt_q == cpu_pkg::INIT_LAST) begin
					i_d = 1'b1; // RQ3
					st_d = cpu_pkg::ST_VEC_LO;
				end
			end
			cpu_pkg::ST_VEC_LO: begin
				lo_d = din;
				st_d = cpu_pkg::ST_VEC_HI;
			end
			cpu_pkg::ST_VEC_HI: begin
				pc_d = {din, lo_q}; // RQ3 RQ9
				st_d = cpu_pkg::ST_FETCH;
			end
			cpu_pkg::ST_FETCH: begin
				if (!irq_n && !i_q) st_d = cpu_pkg::ST_PUSH_H; // RQ6 RQ7
				else begin
					ir_d = din;
					md_d = cpu_pkg::cpu_mode_of(din);
					pc_d = pc_q + 16'h0001;
					if (md_d == cpu_pkg::M_IMP) begin
						case (din)
							cpu_pkg::OP_SEI: i_d = 1'b1;
							cpu_pkg::OP_CLI: i_d = 1'b0;
							cpu_pkg::OP_ASL_A: begin
								{c_d, res} = {a_q, 1'b0}; // RQ13
								ld = 2'h1;
							end
							cpu_pkg::OP_LSR_A: begin
								{res, c_d} = {1'b0, a_q}; // RQ13
								ld = 2'h1;
							end
							default: ;
						endcase
					end
					else st_d = cpu_pkg::ST_OP1;
				end
			end
			cpu_pkg::ST_OP1: begin
				pc_d = pc_q + 16'h0001;
				lo_d = din;
				st_d = cpu_pkg::ST_EXEC;
				case (md_q)
					cpu_pkg::M_IMM: begin
						st_d = cpu_pkg::ST_FETCH;
						res = cpu_pkg::cpu_alu(ir_q[7:5], a_q, din); // RQ14
						if (ir_q == cpu_pkg::OP_LDX_I) ld = 2'h2;
						else if (ir_q == cpu_pkg::OP_LDY_I) ld = 2'h3;
						else ld = 2'h1;
					end
					cpu_pkg::M_ZP: eff_d = {cpu_pkg::ZERO_PAGE, din}; // RQ16
					cpu_pkg::M_ZPX: eff_d = {cpu_pkg::ZERO_PAGE, din + x_q}; // RQ17
					cpu_pkg::M_INDX: begin
						ptr_d = {cpu_pkg::ZERO_PAGE, din + x_q}; // RQ20
						st_d = cpu_pkg::ST_PTR_LO;
					end
					cpu_pkg::M_INDY: begin
						ptr_d = {cpu_pkg::ZERO_PAGE, din};
						st_d = cpu_pkg::ST_PTR_LO;
					end
					cpu_pkg::M_REL: begin
						st_d = cpu_pkg::ST_FETCH;
						if (take) pc_d = pc_q + 16'h0001 + {{8{din[7]}}, din}; // RQ19
					end
					default: st_d = cpu_pkg::ST_OP2;
				endcase
			end
			cpu_pkg::ST_OP2: begin
				pc_d = pc_q + 16'h0001;
				st_d = cpu_pkg::ST_EXEC;
				case (md_q)
					cpu_pkg::M_ABSX: eff_d = {din, lo_q} + {8'h00, x_q}; // RQ18
					cpu_pkg::M_ABSY: eff_d = {din, lo_q} + {8'h00, y_q}; // RQ18
					cpu_pkg::M_JABS: begin
						pc_d = {din, lo_q}; // RQ15
						st_d = cpu_pkg::ST_FETCH;
					end
					cpu_pkg::M_JIND: begin
						ptr_d = {din, lo_q};
						st_d = cpu_pkg::ST_PTR_LO;
					end
					default: eff_d = {din, lo_q}; // RQ15
				endcase
			end
			cpu_pkg::ST_PTR_LO: begin
				lo_d = din;
				st_d = cpu_pkg::ST_PTR_HI;
				if (md_q == cpu_pkg::M_JIND) ptr_d = ptr_q + 16'h0001;
				else ptr_d = {cpu_pkg::ZERO_PAGE, ptr_q[7:0] + 8'h01}; // RQ20
			end
			cpu_pkg::ST_PTR_HI: begin
				st_d = cpu_pkg::ST_EXEC;
				if (md_q == cpu_pkg::M_JIND) begin
					pc_d = {din, lo_q}; // RQ22
					st_d = cpu_pkg::ST_FETCH;
				end
				else if (md_q == cpu_pkg::M_INDY)
					eff_d = {din, lo_q} + {8'h00, y_q}; // RQ21
				else eff_d = {din, lo_q}; // RQ20
			end
			cpu_pkg::ST_EXEC: begin
				st_d = cpu_pkg::ST_FETCH;
				if (!store) begin
					res = cpu_pkg::cpu_alu(ir_q[7:5], a_q, din);
					ld = 2'h1;
				end
			end
			cpu_pkg::ST_PUSH_H: begin
				sp_d = sp_q - 8'h01; // RQ26
				st_d = cpu_pkg::ST_PUSH_L;
			end
			cpu_pkg::ST_PUSH_L: begin
				sp_d = sp_q - 8'h01; // RQ26
				st_d = cpu_pkg::ST_PUSH_P;
			end
			cpu_pkg::ST_PUSH_P: begin
				sp_d = sp_q - 8'h01; // RQ26
				i_d = 1'b1; // RQ9
				st_d = cpu_pkg::ST_VEC_LO;
			end
			default: st_d = cpu_pkg::ST_RST_HOLD;
		endcase
		case (ld)
			2'h1: a_d = res;
			2'h2: x_d = res;
			2'h3: y_d = res;
			default: ;
		endcase
		if (ld != 2'h0) begin
			n_d = res[7];
			z_d = res == 8'h00;
		end
		if (!restart_input_n) st_d = cpu_pkg::ST_RST_HOLD; // RQ1
	end

	// bus cycle for the next state
	always_comb begin
		rw_d = 1'b1; // RQ12 RQ5
		dout_d = dout_q;
		case (st_d)
			cpu_pkg::ST_VEC_LO:
				addr_d = (st_q == cpu_pkg::ST_PUSH_P) ? cpu_pkg::IRQ_VEC
					: cpu_pkg::RST_VEC;
			cpu_pkg::ST_VEC_HI: addr_d = addr_q + 16'h0001;
			cpu_pkg::ST_FETCH, cpu_pkg::ST_OP1, cpu_pkg::ST_OP2: addr_d = pc_d;
			cpu_pkg::ST_PTR_LO, cpu_pkg::ST_PTR_HI: addr_d = ptr_d;
			cpu_pkg::ST_EXEC: begin
				addr_d = eff_d;
				rw_d = !store; // RQ12
				dout_d = a_d;
			end
			cpu_pkg::ST_PUSH_H: begin
				addr_d = {cpu_pkg::STACK_HI, sp_d};
				rw_d = 1'b0;
				dout_d = pc_d[15:8]; // RQ8 RQ26
			end
			cpu_pkg::ST_PUSH_L: begin
				addr_d = {cpu_pkg::STACK_HI, sp_d};
				rw_d = 1'b0;
				dout_d = pc_d[7:0]; // RQ8 RQ26
			end
			cpu_pkg::ST_PUSH_P: begin
				addr_d = {cpu_pkg::STACK_HI, sp_d};
				rw_d = 1'b0;
				dout_d = {n_q, 1'b0, 1'b1, 1'b0, 1'b0, i_q, z_q, c_q}; // RQ8
			end
			default: addr_d = addr_q;
		endcase
	end

	// port registers
	always_comb begin
		dir_d = dir_q;
		out_d = out_q;
		if (wr_ok && addr_q == cpu_pkg::PORT_DIR_ADDR) dir_d = dout_q; // RQ23
		if (wr_ok && addr_q == cpu_pkg::PORT_OUT_ADDR) out_d = dout_q; // RQ11
	end

	always_ff @(posedge clk_sys) begin
		if (wr_ok && addr_q[15:9] == cpu_pkg::INT_PAGES) ram_q[addr_q[7:0]] <= dout_q; // RQ25
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_q <= cpu_pkg::ST_RST_HOLD;
			pc_q <= 16'h0000;
			ptr_q <= 16'h0000;
			eff_q <= 16'h0000;
			addr_q <= 16'h0000;
			{a_q, x_q, y_q, ir_q, lo_q, dout_q} <= 48'h0;
			sp_q <= cpu_pkg::SP_RESET;
			dir_q <= cpu_pkg::PORT_RESET;
			out_q <= cpu_pkg::PORT_RESET;
			md_q <= cpu_pkg::M_IMP;
			cnt_q <= 3'h0;
			{n_q, z_q, c_q, i_q} <= 4'h1;
			rw_q <= 1'b1;
			aoe_q <= 1'b0;
			doe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			pc_q <= pc_d;
			ptr_q <= ptr_d;
			eff_q <= eff_d;
			addr_q <= addr_d;
			{a_q, x_q, y_q, ir_q, lo_q, dout_q} <= {a_d, x_d, y_d, ir_d, lo_d, dout_d};
			sp_q <= sp_d;
			dir_q <= dir_d;
			out_q <= out_d;
			md_q <= md_d;
			cnt_q <= cnt_d;
			{n_q, z_q, c_q, i_q} <= {n_d, z_d, c_d, i_d};
			rw_q <= rw_d;
			aoe_q <= bus_drive_enable; // RQ10
			doe_q <= !rw_d && bus_drive_enable;
		end
	end

	assign address_lines = addr_q;
	assign address_lines_oe = aoe_q;
	assign data_lines_o = dout_q;
	assign data_lines_oe = doe_q;
	assign rw = rw_q;
	assign port_pins_o = out_q;
	assign port_pins_oe = dir_q;

	no_write_reset_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ1
		!restart_input_n |=> rw_q) else $error("write while restart low");
	reset_start_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ2
		st_q == cpu_pkg::ST_RST_HOLD && restart_input_n |=> st_q == cpu_pkg::ST_RST_INIT)
		else $error("reset sequence did not start");
	reset_vector_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ3
		$rose(st_q == cpu_pkg::ST_RST_INIT) ##0 restart_input_n [*6] |=>
		i_q && addr_q == cpu_pkg::RST_VEC) else $error("reset vector wrong");
	irq_masked_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ7
		st_q == cpu_pkg::ST_FETCH && !irq_n && i_q && restart_input_n |=>
		st_q != cpu_pkg::ST_PUSH_H) else $error("masked interrupt taken");
	irq_stack_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ8
		st_q == cpu_pkg::ST_FETCH && !irq_n && !i_q && restart_input_n |=>
		!rw_q && addr_q == {cpu_pkg::STACK_HI, $past(sp_q)}
		&& data_lines_o == $past(pc_q[15:8])) else $error("interrupt push wrong");
	irq_vector_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ9
		st_q == cpu_pkg::ST_PUSH_P && restart_input_n |=>
		i_q && addr_q == cpu_pkg::IRQ_VEC) else $error("interrupt vector wrong");
	addr_float_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ10
		!bus_drive_enable |=> !address_lines_oe) else $error("address driven");
	zp_page_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ17
		st_q == cpu_pkg::ST_EXEC && (md_q == cpu_pkg::M_ZP || md_q == cpu_pkg::M_ZPX)
		|-> addr_q[15:8] == cpu_pkg::ZERO_PAGE) else $error("zero page escaped");
	rw_write_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ12
		!rw_q |-> st_q inside {cpu_pkg::ST_EXEC, cpu_pkg::ST_PUSH_H,
		cpu_pkg::ST_PUSH_L, cpu_pkg::ST_PUSH_P}) else $error("rw low outside write");
endmodule
`default_nettype wire

// *** verification/cpu_mem_model.sv ***
// memory model on the far side of the processor bus
// assumes the core shows one address per clock and reads combinationally
`timescale 1ns/100ps
`default_nettype none
module cpu_mem_model (
	// clock
	input wire logic clk_sys,
	// bus from the core
	input wire logic [15:0] address_lines,
	input wire logic address_lines_oe,
	input wire logic rw,
	input wire logic [7:0] data_lines_o,
	input wire logic data_lines_oe,
	// read data to the core
	output logic [7:0] data_lines_i
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_q;
	initial last_q = 8'h00;
	// floated bus shows the inverse of the last byte, never a stale copy
	assign data_lines_i = address_lines_oe ? mem[address_lines] : ~last_q;
	always @(posedge clk_sys) begin
		last_q <= data_lines_i;
		if (address_lines_oe && !rw && data_lines_oe) begin
			mem[address_lines] <= data_lines_o;
		end
	end
endmodule
`default_nettype wire

// *** verification/tb_cpu_reset_irq_addressing.sv ***
// testbench: runs a small program from the reset vector and checks writes
// assumes cpu_core and the memory model compiled before it
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_reset_irq_addressing;
	logic clk_sys, rstn, restart_input_n, irq_n, bus_drive_enable;
	logic [15:0] address_lines;
	logic address_lines_oe, data_lines_oe, rw;
	logic [7:0] data_lines_i, data_lines_o, port_pins_i, port_pins_o;
	logic [7:0] port_pins_oe, pins_ext;
	logic [23:0] exp_q [$];
	logic [23:0] tbl [];
	logic [23:0] w_exp;
	logic [7:0] prog [];
	integer seed, mismatches, tests_run, n;

	cpu_core i_dut (.clk_sys(clk_sys), .rstn(rstn),
		.restart_input_n(restart_input_n), .irq_n(irq_n),
		.bus_drive_enable(bus_drive_enable), .address_lines(address_lines),
		.address_lines_oe(address_lines_oe), .data_lines_i(data_lines_i),
		.data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
		.rw(rw), .port_pins_i(port_pins_i), .port_pins_o(port_pins_o),
		.port_pins_oe(port_pins_oe));
	cpu_mem_model i_mem (.clk_sys(clk_sys), .address_lines(address_lines),
		.address_lines_oe(address_lines_oe), .rw(rw),
		.data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
		.data_lines_i(data_lines_i));
	// pin level: driven bits from the port, the rest from the peripheral
	assign port_pins_i = (port_pins_oe & port_pins_o) | (~port_pins_oe & pins_ext);

	task automatic check(input string what, input logic [23:0] seen,
		input logic [23:0] expd);
		tests_run++;
		if (seen !== expd) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, expd, seen);
		end
	endtask

	task report_and_stop;
		if (mismatches == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// edges from restart release to the reset vector fetch
	task wait_vec;
		n = 0;
		while (address_lines !== 16'hfffc && n < 50) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check("reset lead", 24'(n >= 7 && n <= 8), 24'h1);
		@(posedge clk_sys);
		#1;
		check("vector high", 24'(address_lines), 24'h00fffd);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// every write cycle on the bus takes the oldest note
	always @(negedge clk_sys) begin
		if (rstn === 1'b1 && rw === 1'b0 && data_lines_oe === 1'b1) begin
			w_exp = 24'hxxxxxx;
			if (exp_q.size() > 0) begin
				w_exp = exp_q.pop_front();
			end
			check("bus write", {address_lines, data_lines_o}, w_exp);
		end
	end

	initial begin
		repeat (5000) @(posedge clk_sys);
		mismatches++;
		report_and_stop;
	end

	initial begin
		seed = 58;
		mismatches = 0;
		tests_run = 0;
		rstn = 1'b0;
		restart_input_n = 1'b0;
		irq_n = 1'b1;
		bus_drive_enable = 1'b1;
		pins_ext = 8'($random(seed));
		prog = '{8'ha9, 8'h5a, 8'h85, 8'h10, 8'h8d, 8'h34, 8'h12, 8'ha2,
			8'hf5, 8'ha0, 8'h10, 8'h95, 8'h20, 8'h9d, 8'h20, 8'h30, 8'h99,
			8'hf8, 8'h12, 8'ha9, 8'h40, 8'h85, 8'h0a, 8'ha9, 8'h22, 8'h85,
			8'h0b, 8'ha9, 8'h77, 8'h81, 8'h15, 8'h91, 8'h0a, 8'ha9, 8'hf8,
			8'h85, 8'h0a, 8'h91, 8'h0a, 8'ha9, 8'h0f, 8'h85, 8'h00, 8'ha9,
			8'ha5, 8'h85, 8'h01, 8'ha5, 8'h01, 8'h8d, 8'h00, 8'h14, 8'ha9,
			8'h00, 8'hd0, 8'h03, 8'h8d, 8'h88, 8'h88, 8'hf0, 8'h03, 8'h8d,
			8'h66, 8'h66, 8'ha9, 8'h41, 8'h0a, 8'h8d, 8'h00, 8'h15, 8'h09,
			8'h0c, 8'h29, 8'hf6, 8'h49, 8'hff, 8'h4a, 8'h8d, 8'h01, 8'h15,
			8'h6c, 8'h00, 8'h30};
		foreach (prog[i]) i_mem.mem[16'h0200 + i] = prog[i];
		tbl = '{24'hfffc00, 24'hfffd02, 24'hfffe00, 24'hffff06, 24'h300000,
			24'h300105, 24'h310000, 24'h0500ad, 24'h050100, 24'h050231,
			24'h0503f0, 24'h0504fb, 24'h050558, 24'h05064c, 24'h050706,
			24'h050805, 24'h06008d, 24'h060100, 24'h060216, 24'h06034c,
			24'h060403, 24'h060506};
		foreach (tbl[i]) i_mem.mem[tbl[i][23:8]] = tbl[i][7:0];
		exp_q = '{24'h00105a, 24'h12345a, 24'h00155a, 24'h31155a,
			24'h13085a, 24'h000a40, 24'h000b22, 24'h224077, 24'h225077,
			24'h000af8, 24'h2308f8, 24'h00000f, 24'h0001a5,
			{16'h1400, (8'ha5 & 8'h0f) | (pins_ext & 8'hf0)},
			24'h888800, 24'h150082, 24'h15013c,
			24'h01ff05, 24'h01fe06, 24'h01fd21,
			24'h160001};
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		check("rw in restart", 24'(rw), 24'h1);
		@(posedge clk_sys);
		restart_input_n <= 1'b1;
		irq_n <= 1'b0;
		wait_vec;
		n = 0;
		while (exp_q.size() > 4 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		// request held low while masked: nothing may be stacked
		repeat (40) @(posedge clk_sys);
		@(negedge clk_sys);
		i_mem.mem[16'h3100] = 8'h01;
		while (exp_q.size() > 0 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		repeat (30) @(posedge clk_sys);
		#1;
		check("queue left", 24'(exp_q.size()), 24'h0);
		check("port dir", 24'(port_pins_oe), 24'h00000f);
		check("port out", 24'(port_pins_o), 24'h0000a5);
		@(posedge clk_sys);
		restart_input_n <= 1'b0;
		bus_drive_enable <= 1'b0;
		irq_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		check("addr float", 24'(address_lines_oe), 24'h0);
		check("rw held", 24'(rw), 24'h1);
		@(posedge clk_sys);
		bus_drive_enable <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		check("addr drive", 24'(address_lines_oe), 24'h1);
		@(posedge clk_sys);
		restart_input_n <= 1'b1;
		wait_vec;
		report_and_stop;
	end
endmodule
`default_nettype wire
